/* htf_regs.vh */
`ifndef HTF_REGS_VH
`define HTF_REGS_VH

// Transmit buffer sizes per channel
`define HTF_TX_DEPTH_D 64
`define HTF_TX_DEPTH_B 128
// Transmit block thresholds
`define HTF_BLK_LARGE 8'h20
`define HTF_BLK_SMALL 8'h10
// Receive side
`define HTF_RX_DEPTH 32
`define HTF_RX_BLK_MASK 12'h01F
`define HTF_LEN_MAX 12'hFFF
// Line framing
`define HTF_FLAG 8'h7E
`define HTF_ABORT_LAST 4'h6
`define HTF_STUFF_RUN 3'h5
`define HTF_CRC_POLY 16'h8408
`define HTF_CRC_INIT 16'hFFFF
// Receive status byte fields
`define HTF_RS_VFR 7
`define HTF_RS_RDO 6
`define HTF_RS_CRC 5
`define HTF_RS_RAB 4
`define HTF_RS_SA_HI 3
`define HTF_RS_SA_LO 2
`define HTF_RS_CR 1
`define HTF_RS_TA 0
// Receive operating modes
`define HTF_MODE_TRANS0 2'h0
`define HTF_MODE_TRANS1 2'h1
`define HTF_MODE_NONAUTO2 2'h2
`define HTF_MODE_OTHER 2'h3

`endif

/* htf_fifo.v */
`timescale 1ns/1ns
module htf_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32
) (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_in_valid,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_in_ready,
  output wire o_out_valid,
  output wire [WIDTH-1:0] o_out_data,
  input wire i_out_ready
);
  localparam AW = $clog2(DEPTH);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0] wp_q;
  reg [AW:0] rp_q;
  wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire empty = (wp_q == rp_q);
  wire push = i_in_valid && !full;
  wire pop = i_out_ready && !empty;

  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem_q[rp_q[AW-1:0]];

  always @(posedge i_clk_sys) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= i_in_data;
    end
  end

  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule // htf_fifo

/* htf_rx_status.v */
`timescale 1ns/1ns
`include "htf_regs.vh"
module htf_rx_status (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_rx_valid,
  input wire [7:0] i_rx_data,
  output wire o_rx_ready,
  input wire i_rx_end,
  input wire i_rx_crc_ok,
  input wire i_rx_vfr,
  input wire i_rx_rab,
  input wire i_rx_rdo,
  input wire i_rx_cr,
  input wire [1:0] i_rx_sapi,
  input wire i_rx_tei,
  input wire [1:0] i_mode,
  input wire i_rmc,
  output wire o_q_valid,
  output wire [7:0] o_q_data,
  input wire i_q_ready,
  output wire [11:0] o_message_length,
  output wire o_count_overflow_flag,
  output reg o_receive_pool_full_irq,
  output reg o_receive_message_end_irq
);
  reg stat_pend_q;
  reg [7:0] stat_q;
  reg [11:0] len_q;
  reg ov_q;
  reg done_q;
  wire addr_ok = (i_mode == `HTF_MODE_TRANS1) || (i_mode == `HTF_MODE_NONAUTO2);
  wire tei_ok = (i_mode != `HTF_MODE_TRANS0);
  wire data_take = i_rx_valid && i_q_ready && !stat_pend_q;
  wire stat_take = stat_pend_q && i_q_ready;
  wire [11:0] len_base = done_q ? 12'h000 : len_q;
  reg [7:0] stat_d;

  always @* begin
    stat_d = 8'h00;
    stat_d[`HTF_RS_VFR] = i_rx_vfr; // R02
    stat_d[`HTF_RS_RDO] = i_rx_rdo;
    stat_d[`HTF_RS_CRC] = i_rx_crc_ok;
    stat_d[`HTF_RS_RAB] = i_rx_rab;
    stat_d[`HTF_RS_CR] = addr_ok & i_rx_cr; // R02
    stat_d[`HTF_RS_SA_HI] = addr_ok & i_rx_sapi[1];
    stat_d[`HTF_RS_SA_LO] = addr_ok & i_rx_sapi[0];
    stat_d[`HTF_RS_TA] = tei_ok & i_rx_tei; // R02
  end

  assign o_rx_ready = i_q_ready && !stat_pend_q;
  assign o_q_valid = stat_pend_q || i_rx_valid;
  assign o_q_data = stat_pend_q ? stat_q : i_rx_data; // R01
  assign o_message_length = len_q; // R03
  assign o_count_overflow_flag = ov_q; // R03

  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      stat_pend_q <= 1'b0;
      stat_q <= 8'h00;
      len_q <= 12'h000;
      ov_q <= 1'b0;
      done_q <= 1'b0;
      o_receive_pool_full_irq <= 1'b0;
      o_receive_message_end_irq <= 1'b0;
    end else begin
      o_receive_pool_full_irq <= 1'b0;
      o_receive_message_end_irq <= 1'b0;
      if (done_q && i_rmc) begin
        done_q <= 1'b0;
        len_q <= 12'h000;
        ov_q <= 1'b0;
      end
      if (i_rx_end && !stat_pend_q) begin
        stat_pend_q <= 1'b1; // R01
        stat_q <= stat_d;
      end
      if (data_take || stat_take) begin
        done_q <= stat_take;
        if (done_q) begin
          ov_q <= 1'b0;
        end
        if (len_base == `HTF_LEN_MAX) begin
          ov_q <= 1'b1; // R03
        end else begin
          len_q <= len_base + 12'h001;
        end
      end
      if (data_take && ((len_base & `HTF_RX_BLK_MASK) == `HTF_RX_BLK_MASK)) begin
        o_receive_pool_full_irq <= 1'b1; // R21
      end
      if (stat_take) begin
        stat_pend_q <= 1'b0;
        o_receive_message_end_irq <= 1'b1; // R22
      end
    end
  end
endmodule // htf_rx_status

/* htf_hdlc_fifo.v */
`timescale 1ns/1ns
`include "htf_regs.vh"
// What this block does
// R01: Status byte appended after each received frame
// R02: Status fields reported per receive mode
// R03: Twelve-bit length count plus overflow flag
// R04: Cyclic transmit buffer, 64 or 128 bytes
// R05: Threshold 16 or 32 on D, 32 on B
// R06: Pool ready after reset or block freed
// R07: Empty mid-frame sends seven ones, underrun
// R08: Late D-channel collision raises message repeat
// R09: Underrun or repeat clears buffer, blocks writes
// R10: Transparent frame sends block, opening flag
// R11: Message end appends CRC and closing flag
// R12: Reset empties buffer, aborts, clears overflow flag, keeps underrun and repeat
// R13: Writes beyond block size set overflow flag
// R14: Pollable write-enable flag for host
// R15: Combined command locks until closing flag
// R16: Single command: ready once block fits
// R17: New block size loads on commands
// R18: Several frames may queue in buffer
// R19: Early channel loss retransmits current frame
// R20: Host writes at most one block each; further writes are still stored and set the overflow flag
// R21: Pool full pulse per received block
// R22: Message end pulse on completed frame
module htf_hdlc_fifo #(
  parameter IS_DCHAN = 1,
  parameter DEPTH = `HTF_TX_DEPTH_D,
  parameter RX_DEPTH = `HTF_RX_DEPTH
) (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_tx_wr_valid,
  input wire [7:0] i_tx_wr_data,
  input wire i_send_transparent_frame_cmd,
  input wire i_message_end_cmd,
  input wire i_transmitter_reset_cmd,
  input wire i_transmit_block_size,
  input wire i_status_read,
  output wire o_transmit_pool_ready_irq,
  output wire o_transmit_underrun_irq,
  output wire o_message_repeat_irq,
  output wire o_transmit_overflow_flag,
  output wire o_fifo_write_enable_flag,
  input wire i_line_bit_req,
  input wire i_collision,
  output wire o_line_tx_bit,
  input wire i_rx_valid,
  input wire [7:0] i_rx_data,
  output wire o_rx_ready,
  input wire i_rx_end,
  input wire i_rx_crc_ok,
  input wire i_rx_vfr,
  input wire i_rx_rab,
  input wire i_rx_rdo,
  input wire i_rx_cr,
  input wire [1:0] i_rx_sapi,
  input wire i_rx_tei,
  input wire [1:0] i_rx_mode,
  input wire i_rx_rmc,
  output wire o_rx_rd_valid,
  output wire [7:0] o_rx_rd_data,
  input wire i_rx_rd_ready,
  output wire [11:0] o_message_length,
  output wire o_count_overflow_flag,
  output wire o_receive_pool_full_irq,
  output wire o_receive_message_end_irq
);
  localparam PW = $clog2(DEPTH);
  localparam [7:0] DEPTH8 = DEPTH;
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_FLAG = 3'h1;
  localparam [2:0] ST_DATA = 3'h2;
  localparam [2:0] ST_CRC = 3'h3;
  localparam [2:0] ST_ABORT = 3'h4;

  function [15:0] crc_bit;
    input [15:0] c;
    input b;
    reg fb;
    begin
      fb = c[0] ^ b;
      crc_bit = {1'b0, c[15:1]} ^ (fb ? `HTF_CRC_POLY : 16'h0000);
    end
  endfunction

  reg [7:0] mem_q [0:DEPTH-1];
  reg endm_q [0:DEPTH-1];
  reg [7:0] wp_q, rp_q, commit_q, fstart_q, sent_q, wcnt_q;
  reg blk_sel_q, lock_q, wait_xpr_q, transmit_overflow_flag_q;
  reg xpr_q, xdu_q, xmr_q;
  reg [2:0] st_q;
  reg [3:0] bitc_q;
  reg [2:0] ones_q;
  reg [7:0] sh_q;
  reg em_q, closing_q, tx_bit_q;
  reg [15:0] crc_q, crcsh_q;

  wire [7:0] blk = (IS_DCHAN != 0 && blk_sel_q) ? `HTF_BLK_SMALL : `HTF_BLK_LARGE; // R05
  wire in_frame = (st_q == ST_FLAG && !closing_q) || st_q == ST_DATA || st_q == ST_CRC;
  wire hold_first = in_frame && (sent_q <= blk);
  wire [7:0] rel = hold_first ? fstart_q : rp_q; // R19
  wire [7:0] used = wp_q - rel;
  wire [7:0] free = DEPTH8 - used;
  wire err_lock = xdu_q | xmr_q;
  wire have_data = (rp_q != commit_q);
  wire cmd_xtf = i_send_transparent_frame_cmd;
  wire cmd_xme = i_message_end_cmd;
  wire cmd_any = cmd_xtf | cmd_xme;
  wire wr_ok = i_tx_wr_valid && !err_lock && !lock_q && (free != 8'h00); // R09
  wire [7:0] wp_n = wr_ok ? wp_q + 8'h01 : wp_q;
  wire [7:0] end_idx = wp_n - 8'h01;
  wire close_edge = (st_q == ST_FLAG) && closing_q && (bitc_q == 4'h0);
  wire stuff = (st_q == ST_DATA || st_q == ST_CRC || close_edge) && (ones_q == `HTF_STUFF_RUN);
  wire [15:0] crc_n = crc_bit(crc_q, sh_q[0]);
  wire [7:0] flag = `HTF_FLAG;

  assign o_transmit_pool_ready_irq = xpr_q;
  assign o_transmit_underrun_irq = xdu_q;
  assign o_message_repeat_irq = xmr_q;
  assign o_transmit_overflow_flag = transmit_overflow_flag_q;
  assign o_fifo_write_enable_flag = !err_lock && !lock_q && (wcnt_q < blk) && (free != 8'h00); // R14
  assign o_line_tx_bit = tx_bit_q;

  // Buffer storage; end marks tag the last byte of a frame
  always @(posedge i_clk_sys) begin
    if (wr_ok) begin
      mem_q[wp_q[PW-1:0]] <= i_tx_wr_data; // R04
      endm_q[wp_q[PW-1:0]] <= 1'b0;
    end
    if (cmd_xme && wp_n != commit_q) begin
      endm_q[end_idx[PW-1:0]] <= 1'b1; // R11
    end
  end

  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wp_q <= 8'h00;
      rp_q <= 8'h00;
      commit_q <= 8'h00;
      fstart_q <= 8'h00;
      sent_q <= 8'h00;
      wcnt_q <= 8'h00;
      blk_sel_q <= 1'b0;
      lock_q <= 1'b0;
      wait_xpr_q <= 1'b0;
      transmit_overflow_flag_q <= 1'b0;
      xpr_q <= 1'b0;
      xdu_q <= 1'b0;
      xmr_q <= 1'b0;
      st_q <= ST_IDLE;
      bitc_q <= 4'h0;
      ones_q <= 3'h0;
      sh_q <= 8'h00;
      em_q <= 1'b0;
      closing_q <= 1'b0;
      tx_bit_q <= 1'b1;
      crc_q <= `HTF_CRC_INIT;
      crcsh_q <= 16'h0000;
    end else begin
      if (i_status_read) begin
        xpr_q <= 1'b0;
        xdu_q <= 1'b0;
        xmr_q <= 1'b0;
      end
      // Host write side
      if (wr_ok) begin
        wp_q <= wp_n; // R18
        if (wcnt_q >= blk) begin
          transmit_overflow_flag_q <= 1'b1; // R13
        end else begin
          wcnt_q <= wcnt_q + 8'h01;
        end
      end
      if (cmd_any) begin
        commit_q <= wp_n; // R10
        wcnt_q <= 8'h00;
        blk_sel_q <= i_transmit_block_size; // R17
        if (cmd_xtf && cmd_xme) begin
          lock_q <= 1'b1; // R15
          wait_xpr_q <= 1'b0;
        end else begin
          wait_xpr_q <= 1'b1; // R16
        end
      end
      if (wait_xpr_q && !lock_q && free >= blk) begin
        xpr_q <= 1'b1; // R06
        wait_xpr_q <= 1'b0;
      end
      // Serial transmitter
      if (i_line_bit_req) begin
        if (stuff) begin
          tx_bit_q <= 1'b0;
          ones_q <= 3'h0;
        end else begin
          case (st_q)
            ST_IDLE: begin
              tx_bit_q <= 1'b1;
              if (have_data) begin
                st_q <= ST_FLAG; // R10
                bitc_q <= 4'h0;
                closing_q <= 1'b0;
                fstart_q <= rp_q;
                sent_q <= 8'h00;
              end
            end
            ST_FLAG: begin
              tx_bit_q <= flag[bitc_q[2:0]];
              bitc_q <= bitc_q + 4'h1;
              if (bitc_q == 4'h7) begin
                bitc_q <= 4'h0;
                if (closing_q && lock_q) begin
                  lock_q <= 1'b0;
                  xpr_q <= 1'b1; // R15
                end
                if (!closing_q || (have_data && !lock_q)) begin
                  st_q <= ST_DATA; // R16
                  closing_q <= 1'b0;
                  fstart_q <= rp_q;
                  sent_q <= 8'h01;
                  crc_q <= `HTF_CRC_INIT;
                  ones_q <= 3'h0;
                  sh_q <= mem_q[rp_q[PW-1:0]];
                  em_q <= endm_q[rp_q[PW-1:0]];
                  rp_q <= rp_q + 8'h01;
                end else begin
                  st_q <= ST_IDLE;
                end
              end
            end
            ST_DATA: begin
              tx_bit_q <= sh_q[0];
              crc_q <= crc_n;
              ones_q <= sh_q[0] ? ones_q + 3'h1 : 3'h0;
              sh_q <= {1'b0, sh_q[7:1]};
              bitc_q <= bitc_q + 4'h1;
              if (bitc_q == 4'h7) begin
                bitc_q <= 4'h0;
                if (em_q) begin
                  st_q <= ST_CRC; // R11
                  crcsh_q <= ~crc_n;
                end else if (have_data) begin
                  sh_q <= mem_q[rp_q[PW-1:0]];
                  em_q <= endm_q[rp_q[PW-1:0]];
                  rp_q <= rp_q + 8'h01;
                  if (sent_q <= blk) begin
                    sent_q <= sent_q + 8'h01;
                  end
                end else begin
                  st_q <= ST_ABORT; // R07
                  xdu_q <= 1'b1;
                  xpr_q <= 1'b1;
                  wp_q <= 8'h00; // R09
                  rp_q <= 8'h00;
                  commit_q <= 8'h00;
                  wcnt_q <= 8'h00;
                  wait_xpr_q <= 1'b0;
                  lock_q <= 1'b0;
                end
              end
            end
            ST_CRC: begin
              tx_bit_q <= crcsh_q[0];
              ones_q <= crcsh_q[0] ? ones_q + 3'h1 : 3'h0;
              crcsh_q <= {1'b0, crcsh_q[15:1]};
              bitc_q <= bitc_q + 4'h1;
              if (bitc_q == 4'hF) begin
                bitc_q <= 4'h0;
                st_q <= ST_FLAG; // R11
                closing_q <= 1'b1;
              end
            end
            ST_ABORT: begin
              tx_bit_q <= 1'b1; // R07
              bitc_q <= bitc_q + 4'h1;
              if (bitc_q == `HTF_ABORT_LAST) begin
                st_q <= ST_IDLE;
                bitc_q <= 4'h0;
              end
            end
            default: begin
              st_q <= ST_IDLE;
            end
          endcase
        end
      end
      // Channel lost while a frame is going out
      if (i_collision && IS_DCHAN != 0 && in_frame) begin
        bitc_q <= 4'h0;
        ones_q <= 3'h0;
        if (hold_first) begin
          rp_q <= fstart_q; // R19
          st_q <= ST_IDLE;
        end else begin
          xmr_q <= 1'b1; // R08
          xpr_q <= 1'b1;
          st_q <= ST_ABORT;
          wp_q <= 8'h00; // R09
          rp_q <= 8'h00;
          commit_q <= 8'h00;
          wcnt_q <= 8'h00;
          wait_xpr_q <= 1'b0;
          lock_q <= 1'b0;
        end
      end
      if (i_transmitter_reset_cmd) begin
        wp_q <= 8'h00; // R12
        rp_q <= 8'h00;
        commit_q <= 8'h00;
        wcnt_q <= 8'h00;
        transmit_overflow_flag_q <= 1'b0;
        lock_q <= 1'b0;
        wait_xpr_q <= 1'b0;
        blk_sel_q <= i_transmit_block_size; // R17
        st_q <= ST_ABORT; // R12
        bitc_q <= 4'h0;
        ones_q <= 3'h0;
        closing_q <= 1'b0;
        xpr_q <= 1'b1; // R06
      end
    end
  end

  wire q_valid;
  wire [7:0] q_data;
  wire q_ready;

  htf_rx_status u_rx_status (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_rx_valid(i_rx_valid),
    .i_rx_data(i_rx_data),
    .o_rx_ready(o_rx_ready),
    .i_rx_end(i_rx_end),
    .i_rx_crc_ok(i_rx_crc_ok),
    .i_rx_vfr(i_rx_vfr),
    .i_rx_rab(i_rx_rab),
    .i_rx_rdo(i_rx_rdo),
    .i_rx_cr(i_rx_cr),
    .i_rx_sapi(i_rx_sapi),
    .i_rx_tei(i_rx_tei),
    .i_mode(i_rx_mode),
    .i_rmc(i_rx_rmc),
    .o_q_valid(q_valid),
    .o_q_data(q_data),
    .i_q_ready(q_ready),
    .o_message_length(o_message_length),
    .o_count_overflow_flag(o_count_overflow_flag),
    .o_receive_pool_full_irq(o_receive_pool_full_irq),
    .o_receive_message_end_irq(o_receive_message_end_irq)
  );

  htf_fifo #(
    .WIDTH(8),
    .DEPTH(RX_DEPTH)
  ) u_rx_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_in_valid(q_valid),
    .i_in_data(q_data),
    .o_in_ready(q_ready),
    .o_out_valid(o_rx_rd_valid),
    .o_out_data(o_rx_rd_data),
    .i_out_ready(i_rx_rd_ready)
  );
endmodule // htf_hdlc_fifo

/* htf_hdlc_fifo_assertions.sv */
`timescale 1ns/1ns
module htf_hdlc_fifo_assertions (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_status_read,
  input wire i_transmitter_reset_cmd,
  input wire i_send_transparent_frame_cmd,
  input wire i_message_end_cmd,
  input wire o_transmit_pool_ready_irq,
  input wire o_transmit_underrun_irq,
  input wire o_message_repeat_irq,
  input wire o_transmit_overflow_flag,
  input wire o_fifo_write_enable_flag,
  input wire o_receive_pool_full_irq,
  input wire o_receive_message_end_irq,
  input wire [11:0] o_message_length,
  input wire o_count_overflow_flag
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  sequence s_transmitter_reset_cmd;
    i_transmitter_reset_cmd;
  endsequence
  sequence s_ready_soon;
    ##[1:4] o_transmit_pool_ready_irq;
  endsequence
  sequence s_combined;
    i_send_transparent_frame_cmd && i_message_end_cmd;
  endsequence
  AST_TRANSMITTER_RESET_CMD_READY: assert property (s_transmitter_reset_cmd |-> s_ready_soon)
    else $error("pool ready missing after reset command");
  AST_COMB_LOCK: assert property (s_combined |=> !o_fifo_write_enable_flag)
    else $error("buffer open after combined command");
  AST_UNDERRUN_READY: assert property ($rose(o_transmit_underrun_irq) |-> o_transmit_pool_ready_irq)
    else $error("underrun without pool ready");
  AST_ERR_LOCK: assert property ((o_transmit_underrun_irq || o_message_repeat_irq)
    |-> !o_fifo_write_enable_flag)
    else $error("writes open while error pending");
  AST_IRQ_STICKY: assert property (o_transmit_underrun_irq && !i_status_read
    |=> o_transmit_underrun_irq)
    else $error("underrun dropped without read");
  AST_TRANSMIT_OVERFLOW_FLAG_HOLD: assert property (o_transmit_overflow_flag && !i_transmitter_reset_cmd
    |=> o_transmit_overflow_flag)
    else $error("overflow flag dropped");
  AST_RPF_PULSE: assert property (o_receive_pool_full_irq |=> !o_receive_pool_full_irq)
    else $error("pool full longer than one cycle");
  AST_RME_PULSE: assert property (o_receive_message_end_irq |=> !o_receive_message_end_irq)
    else $error("message end longer than one cycle");
  AST_LEN_SAT: assert property (o_count_overflow_flag |-> o_message_length == 12'hFFF)
    else $error("length not saturated on overflow");
endmodule // htf_hdlc_fifo_assertions
bind htf_hdlc_fifo htf_hdlc_fifo_assertions u_chk (.i_clk_sys, .i_rst, .i_status_read,
  .i_transmitter_reset_cmd, .i_send_transparent_frame_cmd, .i_message_end_cmd,
  .o_transmit_pool_ready_irq, .o_transmit_underrun_irq, .o_message_repeat_irq,
  .o_transmit_overflow_flag, .o_fifo_write_enable_flag, .o_receive_pool_full_irq,
  .o_receive_message_end_irq, .o_message_length, .o_count_overflow_flag);

/* htf_line_model.sv */
`timescale 1ns/1ns
module htf_line_model (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_en,
  input wire logic i_bit,
  output logic o_req,
  output logic [7:0] o_run,
  output logic [7:0] o_flags
);
  logic smp_q;
  logic [7:0] sh_q;
  // Bit slot every second cycle while enabled; bit sampled one cycle later
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_req <= 1'b0;
      smp_q <= 1'b0;
      sh_q <= 8'h00;
      o_run <= 8'h00;
      o_flags <= 8'h00;
    end else begin
      o_req <= i_en && !o_req;
      smp_q <= o_req;
      if (smp_q) begin
        sh_q <= {i_bit, sh_q[7:1]};
        o_run <= i_bit ? o_run + {7'h00, o_run != 8'hFF} : 8'h00;
        if ({i_bit, sh_q[7:1]} == 8'h7E)
          o_flags <= o_flags + 8'h01;
      end
    end
  end
endmodule // htf_line_model

/* htf_hdlc_fifo_tb_top.sv */
`timescale 1ns/1ns
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("BAD %s exp %h got %h", nm, e, a); end end
`define WAITC(c, l) begin int k; k = 0; while (!(c) && k < (l)) begin \
  @(negedge i_clk_sys); k++; end end
module htf_hdlc_fifo_tb_top;
  logic i_clk_sys, i_rst, wr_v, send_transparent_frame_cmd, message_end_cmd, transmitter_reset_cmd, blk, st_rd, lreq, lbit, line_en, coll;
  logic rx_v, rx_end, rd_rdy, rmc, pr, ud, mr, transmit_overflow_flag, we, rx_rdy, rd_v, receive_pool_full_irq, receive_message_end_irq, cov;
  logic [7:0] wr_d, rx_d, rd_d, run, flags, rx_last, sts, f0;
  logic [1:0] mode;
  logic [11:0] len;
  int fail_count, num_checks, rpf_cnt, rme_cnt;
  htf_hdlc_fifo dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_tx_wr_valid(wr_v),
    .i_tx_wr_data(wr_d), .i_send_transparent_frame_cmd(send_transparent_frame_cmd), .i_message_end_cmd(message_end_cmd),
    .i_transmitter_reset_cmd(transmitter_reset_cmd), .i_transmit_block_size(blk), .i_status_read(st_rd),
    .o_transmit_pool_ready_irq(pr), .o_transmit_underrun_irq(ud), .o_message_repeat_irq(mr),
    .o_transmit_overflow_flag(transmit_overflow_flag), .o_fifo_write_enable_flag(we), .i_line_bit_req(lreq),
    .i_collision(coll), .o_line_tx_bit(lbit), .i_rx_valid(rx_v), .i_rx_data(rx_d),
    .o_rx_ready(rx_rdy), .i_rx_end(rx_end), .i_rx_crc_ok(sts[5]), .i_rx_vfr(sts[7]),
    .i_rx_rab(sts[4]), .i_rx_rdo(sts[6]), .i_rx_cr(sts[1]), .i_rx_sapi(sts[3:2]),
    .i_rx_tei(sts[0]), .i_rx_mode(mode), .i_rx_rmc(rmc), .o_rx_rd_valid(rd_v),
    .o_rx_rd_data(rd_d), .i_rx_rd_ready(rd_rdy), .o_message_length(len),
    .o_count_overflow_flag(cov), .o_receive_pool_full_irq(receive_pool_full_irq),
    .o_receive_message_end_irq(receive_message_end_irq));
  htf_line_model u_line (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_en(line_en), .i_bit(lbit),
    .o_req(lreq), .o_run(run), .o_flags(flags));
  initial begin
    i_clk_sys = 0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  // Host drains the receive buffer continuously
  always @(posedge i_clk_sys) begin
    if (rd_v && rd_rdy) rx_last <= rd_d;
    if (receive_pool_full_irq) rpf_cnt <= rpf_cnt + 1;
    if (receive_message_end_irq) rme_cnt <= rme_cnt + 1;
  end
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task pulse_cmd(input logic t, input logic e, input logic r);
    begin
      send_transparent_frame_cmd = t;
      message_end_cmd = e;
      transmitter_reset_cmd = r;
      @(negedge i_clk_sys);
      send_transparent_frame_cmd = 0;
      message_end_cmd = 0;
      transmitter_reset_cmd = 0;
    end
  endtask
  task rd_st;
    begin
      st_rd = 1;
      @(negedge i_clk_sys);
      st_rd = 0;
    end
  endtask
  task tx_wr(input int n);
    begin
      for (int i = 0; i < n; i++) begin
        wr_v = 1;
        wr_d = i[7:0];
        @(negedge i_clk_sys);
      end
      wr_v = 0;
    end
  endtask
  task transmitter_reset_cmd_clean;
    begin
      pulse_cmd(0, 0, 1);
      `WAITC(pr, 8)
      `CHK("ready after reset cmd", 1'b1, pr)
      rd_st;
    end
  endtask
  task t_ovf(input logic sel, input int n);
    begin
      blk = sel;
      transmitter_reset_cmd_clean;
      tx_wr(n);
      `CHK("overflow at limit", 1'b0, transmit_overflow_flag)
      tx_wr(1);
      `CHK("overflow past limit", 1'b1, transmit_overflow_flag)
    end
  endtask
  task t_comb;
    begin
      transmitter_reset_cmd_clean;
      f0 = flags;
      tx_wr(8);
      pulse_cmd(1, 1, 0);
      `CHK("locked", 1'b0, we)
      `CHK("early ready", 1'b0, pr)
      line_en = 1;
      `WAITC(pr, 3000)
      `CHK("ready after frame", 1'b1, pr)
      @(negedge i_clk_sys);
      `CHK("flags sent", 1'b1, (flags - f0) >= 8'h02)
      line_en = 0;
      rd_st;
    end
  endtask
  task t_under;
    begin
      transmitter_reset_cmd_clean;
      tx_wr(32);
      pulse_cmd(1, 0, 0);
      `WAITC(pr, 8)
      `CHK("ready with room", 1'b1, pr)
      rd_st;
      line_en = 1;
      `WAITC(ud, 3000)
      `CHK("underrun", 1'b1, ud)
      `CHK("ready with underrun", 1'b1, pr)
      `CHK("writes locked", 1'b0, we)
      `WAITC(run >= 8'h07, 100)
      `CHK("abort ones", 1'b1, run >= 8'h07)
      rd_st;
      `CHK("writes open", 1'b1, we)
      line_en = 0;
    end
  endtask
  task t_coll(input logic late);
    begin
      transmitter_reset_cmd_clean;
      if (late) begin
        tx_wr(32);
        pulse_cmd(1, 0, 0);
        `WAITC(pr, 8)
        rd_st;
      end
      f0 = flags;
      tx_wr(8);
      pulse_cmd(1, 1, 0);
      line_en = 1;
      repeat (late ? 600 : 100) @(negedge i_clk_sys);
      coll = 1;
      @(negedge i_clk_sys);
      coll = 0;
      `CHK("repeat irq", late, mr)
      `CHK("ready with repeat", late, pr)
      `CHK("writes locked at collision", 1'b0, we)
      if (!late) begin
        `WAITC(pr, 3000)
        @(negedge i_clk_sys);
        `CHK("flags with retry", 8'h03, flags - f0)
      end
      line_en = 0;
      rd_st;
    end
  endtask
  task t_rx(input logic [1:0] m, input int n, input logic [7:0] s);
    int r0;
    int p0;
    logic [7:0] ex;
    begin
      mode = m;
      sts = s;
      r0 = rme_cnt;
      p0 = rpf_cnt;
      ex = {s[7:4], (m == 2'h1 || m == 2'h2) ? s[3:1] : 3'h0, (m != 2'h0) ? s[0] : 1'b0};
      for (int i = 0; i < n; i++) begin
        rx_v = 1;
        rx_d = i[7:0];
        `WAITC(rx_rdy, 100)
        @(negedge i_clk_sys);
      end
      rx_v = 0;
      rx_end = 1;
      @(negedge i_clk_sys);
      rx_end = 0;
      `WAITC(rme_cnt != r0, 100)
      `WAITC(!rd_v, 40)
      `CHK("status byte", ex, rx_last)
      `CHK("length", 12'(n + 1), len)
      `CHK("pool full", n >= 32, rpf_cnt != p0)
      `CHK("message end", 1, rme_cnt - r0)
      `CHK("no length overflow", 1'b0, cov)
      rmc = 1;
      @(negedge i_clk_sys);
      rmc = 0;
    end
  endtask
  initial begin
    {wr_v, send_transparent_frame_cmd, message_end_cmd, transmitter_reset_cmd, blk, st_rd, line_en, coll, rx_v, rx_end, rmc} = 0;
    {wr_d, rx_d, sts, mode, fail_count, num_checks} = 0;
    rd_rdy = 1;
    i_rst = 1;
    repeat (6) @(negedge i_clk_sys);
    i_rst = 0;
    `CHK("write enable idle", 1'b1, we)
    `CHK("line idle", 1'b1, lbit)
    t_ovf(0, 32);
    t_ovf(1, 16);
    blk = 0;
    t_comb;
    t_under;
    t_coll(1'b0);
    t_coll(1'b1);
    t_rx(2'h0, 3, 8'hA7);
    t_rx(2'h1, 3, 8'h5B);
    t_rx(2'h2, 3, 8'hEE);
    t_rx(2'h3, 33, 8'h3D);
    end_sim;
  end
  initial begin
    repeat (60000) @(posedge i_clk_sys);
    fail_count++;
    end_sim;
  end
endmodule // htf_hdlc_fifo_tb_top
